/* logic/color_pipe.sv */
// file: top of the overlapped color measurement pipeline
`timescale 1ns/1ps
// Contract
// - five ordered stages from exposure to output
// - value N output three cycles after exposure
// - next value follows one cycle later
// - cycle period is reciprocal of measuring rate
// - triggered output starts three cycles after trigger
// - rising trigger edge yields one output value
// - at most sixteen taught colors stored
// - both buttons held ten seconds restores defaults
// - factory reset only at top privilege
module color_pipe #(
  parameter int unsigned CLK_HZ      = color_pipe_pkg::CLK_HZ,
  parameter logic [31:0] HOLD_CYCLES = color_pipe_pkg::HOLD_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [11:0] rate_hz_i,
  input  wire logic        rate_load_i,
  input  wire logic [15:0] sample_i,
  input  wire logic        trig_en_i,
  input  wire logic        trig_pin_i,
  input  wire logic        dark_btn_i,
  input  wire logic        teach_btn_i,
  input  wire logic        teach_i,
  input  wire logic        top_priv_i,
  output logic             cycle_o,
  output logic [15:0]      value_o,
  output logic             value_valid_o,
  input  wire logic        value_ready_i,
  output logic             in_ready_o,
  output logic [15:0]      near_dist_o,
  output logic [4:0]       table_count_o,
  output logic             factory_o,
  output logic             overflow_o
);
  // ------------------------------------------------------------
  // synchronisers for pins
  // ------------------------------------------------------------
  logic [2:0] trig_s_q;
  logic [2:0] dark_s_q;
  logic [2:0] teach_s_q;
  logic       trig_lvl_q;
  logic       both_lvl_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      trig_s_q   <= 3'h0;
      dark_s_q   <= 3'h0;
      teach_s_q  <= 3'h0;
      trig_lvl_q <= 1'b0;
      both_lvl_q <= 1'b0;
    end
    else
    begin
      trig_s_q  <= {trig_s_q[1:0], trig_pin_i};
      dark_s_q  <= {dark_s_q[1:0], dark_btn_i};
      teach_s_q <= {teach_s_q[1:0], teach_btn_i};
      // a change counts once stages two and three agree
      if (trig_s_q[1] == trig_s_q[2])
      begin
        trig_lvl_q <= trig_s_q[2];
      end
      if ((dark_s_q[1] == dark_s_q[2]) && (teach_s_q[1] == teach_s_q[2]))
      begin
        both_lvl_q <= dark_s_q[2] && teach_s_q[2];
      end
    end
  end

  // ------------------------------------------------------------
  // measuring-cycle divider
  // ------------------------------------------------------------
  logic [11:0] rate_q;
  logic [25:0] div_len_q;
  logic [25:0] div_q;
  logic        tick;

  function automatic logic [11:0] clamp_rate(input logic [11:0] r);
    if (r < color_pipe_pkg::RATE_MIN_HZ)
    begin
      return color_pipe_pkg::RATE_MIN_HZ;
    end
    if (r > color_pipe_pkg::RATE_MAX_HZ)
    begin
      return color_pipe_pkg::RATE_MAX_HZ;
    end
    return r;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (reset_i || factory_o)
    begin
      rate_q <= color_pipe_pkg::RATE_RESET_HZ;
    end
    else if (rate_load_i)
    begin
      rate_q <= clamp_rate(rate_hz_i);
    end
  end

  // period in clocks is clock rate over measuring rate
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      div_len_q <= 26'(CLK_HZ / 32'(color_pipe_pkg::RATE_RESET_HZ));
    end
    else
    begin
      div_len_q <= 26'(CLK_HZ / {20'h0_0000, rate_q});
    end
  end

  assign tick = (div_q >= div_len_q - 26'h000_0001);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      div_q   <= color_pipe_pkg::DIV_RESET;
      cycle_o <= 1'b0;
    end
    else
    begin
      div_q   <= tick ? color_pipe_pkg::DIV_RESET : div_q + 26'h000_0001;
      cycle_o <= tick;
    end
  end

  // ------------------------------------------------------------
  // trigger: rising edge arms a single exposure
  // ------------------------------------------------------------
  logic        trig_prev_q;
  logic        trig_pend_q;
  logic        expose;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      trig_prev_q <= 1'b0;
      trig_pend_q <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_lvl_q;
      // an edge on the tick itself is used at once; pending it too would expose twice
      if (trig_lvl_q && !trig_prev_q && !tick)
      begin
        trig_pend_q <= 1'b1;
      end
      else if (tick)
      begin
        trig_pend_q <= 1'b0;
      end
    end
  end

  // free run when triggering is off, else one exposure per edge
  assign expose = tick && (!trig_en_i || trig_pend_q || (trig_lvl_q && !trig_prev_q));

  // ------------------------------------------------------------
  // stages: exposure, conversion, compute, distance, output
  // ------------------------------------------------------------
  logic [15:0] exp_q;
  logic [15:0] conv_q;
  logic [15:0] avg_q;
  logic [3:0]  vld_q;
  logic [15:0] ref_tab [color_pipe_pkg::TABLE_DEPTH];
  logic [4:0]  count_q;
  logic [15:0] best;
  logic [15:0] d;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  always_comb
  begin
    best = 16'hFFFF;
    d    = 16'h0000;
    for (int i = 0; i < color_pipe_pkg::TABLE_DEPTH; i++)
    begin
      d = absdiff(avg_q, ref_tab[i]);
      if ((5'(i) < count_q) && (d < best))
      begin
        best = d;
      end
    end
  end

  // each stage moves on every tick; averaging depth is one value, as at factory settings
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      vld_q  <= 4'h0;
      exp_q  <= 16'h0000;
      conv_q <= 16'h0000;
      avg_q  <= 16'h0000;
    end
    else if (tick)
    begin
      exp_q  <= sample_i;
      conv_q <= exp_q;
      avg_q  <= conv_q;
      vld_q  <= {vld_q[2:0], expose};
    end
  end

  // output stage fires three cycles after exposure
  logic        push;
  assign push = tick && vld_q[2];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      near_dist_o <= 16'h0000;
      overflow_o  <= 1'b0;
    end
    else if (push)
    begin
      near_dist_o <= best;
      // pipeline never stalls: a full sink drops the value
      overflow_o  <= !in_ready_o;
    end
  end

  color_fifo #(
    .WIDTH (color_pipe_pkg::DATA_W),
    .DEPTH (color_pipe_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_data_i   (avg_q),
    .in_valid_i  (push),
    .in_ready_o  (in_ready_o),
    .out_data_o  (value_o),
    .out_valid_o (value_valid_o),
    .out_ready_i (value_ready_i)
  );

  // ------------------------------------------------------------
  // color table and factory reset
  // ------------------------------------------------------------
  logic [31:0] hold_q;

  always_ff @(posedge clk_i)
  begin
    if (teach_i && (count_q < 5'(color_pipe_pkg::TABLE_DEPTH)))
    begin
      ref_tab[count_q[3:0]] <= avg_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || factory_o)
    begin
      count_q <= color_pipe_pkg::COUNT_RESET;
    end
    else if (teach_i && (count_q < 5'(color_pipe_pkg::TABLE_DEPTH)))
    begin
      count_q <= count_q + 5'h01;
    end
  end

  assign table_count_o = count_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !both_lvl_q || !top_priv_i)
    begin
      hold_q    <= 32'h0000_0000;
      factory_o <= 1'b0;
    end
    else if (hold_q == HOLD_CYCLES - 32'h0000_0001)
    begin
      hold_q    <= hold_q + 32'h0000_0001;
      factory_o <= 1'b1;
    end
    else
    begin
      factory_o <= 1'b0;
      if (hold_q < HOLD_CYCLES)
      begin
        hold_q <= hold_q + 32'h0000_0001;
      end
    end
  end
endmodule

/* common/color_pipe_pkg.sv */
// package: constants and types for the color measurement pipeline
package color_pipe_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned FIFO_DEPTH      = 8;
  localparam int unsigned LATENCY_CYCLES  = 3;
  localparam int unsigned TABLE_DEPTH     = 16;
  localparam int unsigned HOLD_TIME_S     = 10;
  // default measuring rate (Hz) at factory settings
  localparam logic [11:0] RATE_RESET_HZ   = 12'h00_FA;
  localparam logic [11:0] RATE_MIN_HZ     = 12'h00_14;
  localparam logic [11:0] RATE_MAX_HZ     = 12'h07_D0;
  localparam logic [31:0] HOLD_CYCLES     = 32'(HOLD_TIME_S * CLK_HZ);
  localparam logic [25:0] DIV_RESET       = 26'h000_0000;
  localparam logic [4:0]  COUNT_RESET     = 5'h00;
  typedef enum logic [1:0] {
    TRIG_OFF  = 2'b00,
    TRIG_ARM  = 2'b01,
    TRIG_WAIT = 2'b11
  } trig_state_t;
endpackage

/* logic/color_fifo.sv */
// file: parameterised valid/ready FIFO
`timescale 1ns/1ps
module color_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* bench/color_source.sv */
// partner model: detector sample source, one new sample per measuring cycle
`timescale 1ns/1ps
module color_source (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        cycle_i,
  output logic      [15:0] sample_o
);
  // the sample doubles as a tick index, so the bench knows which exposure a value came from
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sample_o <= 16'h0000;
    else if (cycle_i)
      sample_o <= sample_o + 16'h0001;
  end
endmodule

/* bench/color_pipe_monitor.sv */
// checker: port-level assertions for the color pipeline
`timescale 1ns/1ps
module color_pipe_monitor (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        top_priv_i,
  input wire logic        dark_btn_i,
  input wire logic        teach_btn_i,
  input wire logic        cycle_o,
  input wire logic [15:0] value_o,
  input wire logic        value_valid_o,
  input wire logic        value_ready_i,
  input wire logic [4:0]  table_count_o,
  input wire logic        factory_o,
  input wire logic        overflow_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  tick_pulse_a: assert property (cycle_o |=> !cycle_o [*8])
    else $error("cycle pulse too long");
  value_hold_a: assert property (value_valid_o && !value_ready_i |=> value_valid_o && $stable(value_o))
    else $error("output dropped while stalled");
  push_align_a: assert property ($rose(value_valid_o) |-> cycle_o)
    else $error("output not on a cycle boundary");
  overflow_align_a: assert property ($rose(overflow_o) |-> cycle_o)
    else $error("overflow off a cycle boundary");
  table_max_a: assert property (table_count_o <= 5'h10)
    else $error("too many taught colors");
  table_step_a: assert property ($changed(table_count_o) |->
    (table_count_o == $past(table_count_o) + 5'h01) || (table_count_o == 5'h00))
    else $error("table count jumped");
  factory_priv_a: assert property (factory_o |-> $past(top_priv_i))
    else $error("factory reset without privilege");
  factory_btns_a: assert property (factory_o |-> $past(dark_btn_i, 8) && $past(teach_btn_i, 8))
    else $error("factory reset without both buttons");
  factory_clear_a: assert property (factory_o |-> ##[0:1] table_count_o == 5'h00)
    else $error("factory reset kept the table");
endmodule
bind color_pipe color_pipe_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .top_priv_i(top_priv_i),
  .dark_btn_i(dark_btn_i), .teach_btn_i(teach_btn_i), .cycle_o(cycle_o), .value_o(value_o),
  .value_valid_o(value_valid_o), .value_ready_i(value_ready_i), .table_count_o(table_count_o),
  .factory_o(factory_o), .overflow_o(overflow_o));

/* bench/color_pipe_tb.sv */
// testbench: color measurement pipeline
`timescale 1ns/1ps
module color_pipe_tb;
  // scaled clock rate and hold time keep the run short; the divider logic is unchanged
  localparam int unsigned SIM_HZ   = 32'h0003_0D40;
  localparam logic [31:0] SIM_HOLD = 32'h0000_0400;
  logic        clk_i = 1'b0;
  logic [11:0] rate_hz_i = 12'hFFF;
  logic        reset_i = 1'b1;
  logic        rate_load_i = 1'b0;
  logic        trig_en_i = 1'b0;
  logic        trig_pin_i = 1'b0;
  logic        dark_btn_i = 1'b0;
  logic        teach_btn_i = 1'b0;
  logic        teach_i = 1'b0;
  logic        top_priv_i = 1'b0;
  logic        value_ready_i = 1'b0;
  logic        cycle_o, value_valid_o, in_ready_o, factory_o, overflow_o;
  logic [15:0] value_o, sample_i, near_dist_o;
  logic [4:0]  table_count_o;
  int          bad_count = 0;
  int          check_count = 0;
  int          clocks = 0;

  color_pipe #(.CLK_HZ(SIM_HZ), .HOLD_CYCLES(SIM_HOLD)) uut (.clk_i(clk_i), .reset_i(reset_i), .rate_hz_i(rate_hz_i),
    .rate_load_i(rate_load_i), .sample_i(sample_i), .trig_en_i(trig_en_i), .trig_pin_i(trig_pin_i),
    .dark_btn_i(dark_btn_i), .teach_btn_i(teach_btn_i), .teach_i(teach_i), .top_priv_i(top_priv_i),
    .cycle_o(cycle_o), .value_o(value_o), .value_valid_o(value_valid_o), .value_ready_i(value_ready_i),
    .in_ready_o(in_ready_o), .near_dist_o(near_dist_o), .table_count_o(table_count_o),
    .factory_o(factory_o), .overflow_o(overflow_o));
  color_source src (.clk_i(clk_i), .reset_i(reset_i), .cycle_i(cycle_o), .sample_o(sample_i));

  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) clocks++;

  task automatic finish_test;
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bound covers two cycles at the slowest measuring rate
  task automatic wait_tick(input logic [15:0] n);
    for (int i = 0; i < 20000 && sample_i !== n; i++)
      @(negedge clk_i);
    if (sample_i !== n)
    begin
      bad_count++;
      finish_test();
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic teach_fill;
    for (int k = 0; k < 17; k++)
    begin
      teach_i = 1'b1;
      @(negedge clk_i);
      teach_i = 1'b0;
      repeat (2) @(negedge clk_i);
      check(16'(table_count_o), 16'((k < 16) ? k + 1 : 16));
    end
  endtask

  task automatic button_check;
    int fired = 0;
    int n;
    int t0;
    dark_btn_i = 1'b1;
    teach_btn_i = 1'b1;
    repeat (2000)
    begin
      @(negedge clk_i);
      if (factory_o !== 1'b0)
        fired++;
    end
    check(16'(fired), 16'h0000);
    check(16'(table_count_o), 16'h0010);
    // a short release must restart the hold time
    top_priv_i = 1'b1;
    repeat (600) @(negedge clk_i);
    teach_btn_i = 1'b0;
    repeat (10) @(negedge clk_i);
    teach_btn_i = 1'b1;
    for (n = 0; n < 1200 && factory_o !== 1'b1; n++)
      @(negedge clk_i);
    check(16'(n >= SIM_HOLD && n <= SIM_HOLD + 8), 16'h0001);
    @(negedge clk_i);
    check(16'(factory_o), 16'h0000);
    check(16'(table_count_o), 16'h0000);
    dark_btn_i = 1'b0;
    teach_btn_i = 1'b0;
    wait_tick(sample_i + 16'h0001);
    t0 = clocks;
    wait_tick(sample_i + 16'h0001);
    check(16'(clocks - t0), 16'(SIM_HZ / 32'(color_pipe_pkg::RATE_RESET_HZ)));
  endtask

  task automatic stream_check;
    logic [15:0] got[$];
    logic [15:0] base;
    int          t0;
    wait_tick(16'h0004);
    t0 = clocks;
    wait_tick(16'h0005);
    check(16'(clocks - t0), 16'(SIM_HZ / 32'(color_pipe_pkg::RATE_MAX_HZ)));
    base = sample_i;
    // every taught entry holds zero, so the distance equals the value
    check(near_dist_o, base - 16'h0004);
    value_ready_i = 1'b1;
    for (int k = 0; k < 12 && value_valid_o === 1'b1; k++)
    begin
      got.push_back(value_o);
      @(negedge clk_i);
    end
    check(got[got.size() - 1], base - 16'h0004);
    check(got[got.size() - 2], base - 16'h0005);
    // a stalled sink fills the buffer; later values are dropped and flagged
    value_ready_i = 1'b0;
    wait_tick(base + 16'h000A);
    check(16'(overflow_o), 16'h0001);
    check(16'(in_ready_o), 16'h0000);
    value_ready_i = 1'b1;
  endtask

  task automatic trig_check;
    logic [15:0] e;
    int          hits = 0;
    trig_en_i = 1'b1;
    wait_tick(sample_i + 16'h0001);
    e = sample_i;
    // held high on purpose: only the rising edge may start a value
    trig_pin_i = 1'b1;
    for (int k = 0; k < 6000 && sample_i !== e + 16'h0005; k++)
    begin
      if (value_valid_o === 1'b1 && value_o >= e)
      begin
        hits++;
        check(value_o, e);
        check(sample_i - e, 16'h0003);
      end
      @(negedge clk_i);
    end
    check(16'(hits), 16'h0001);
  endtask

  initial
  begin
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    rate_load_i = 1'b1;
    @(negedge clk_i);
    rate_load_i = 1'b0;
    teach_fill();
    stream_check();
    button_check();
    trig_check();
    finish_test();
  end
endmodule
